// >>> core/cmp_vref_pkg.sv
// constants and carrier types for the dual comparator and reference control block
// assumes a single 125 MHz clock domain and a simple strobe register port
package cmp_vref_pkg;

	localparam logic [3:0]  ADDR_CMP_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_REF_CTRL   = 4'h1;
	localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h3;

	localparam logic [15:0] CMP_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] REF_CTRL_RESET  = 16'h0000;
	localparam logic [1:0]  IRQ_RESET       = 2'h0;

	// writable bits of the comparator control word; flags and results excluded
	localparam logic [15:0] CMP_CTRL_WMASK  = 16'h8f3f;
	localparam logic [15:0] REF_CTRL_WMASK  = 16'h00ff;

	localparam int BIT_IDLE_STOP  = 15;
	localparam int BIT_CMP2_EVT   = 13;
	localparam int BIT_CMP1_EVT   = 12;
	localparam int BIT_CMP2_ON    = 11;
	localparam int BIT_CMP1_ON    = 10;
	localparam int BIT_CMP2_PAD   = 9;
	localparam int BIT_CMP1_PAD   = 8;
	localparam int BIT_CMP2_RES   = 7;
	localparam int BIT_CMP1_RES   = 6;
	localparam int BIT_CMP2_INV   = 5;
	localparam int BIT_CMP1_INV   = 4;
	localparam int BIT_CMP2_MINUS = 3;
	localparam int BIT_CMP2_PLUS  = 2;
	localparam int BIT_CMP1_MINUS = 1;
	localparam int BIT_CMP1_PLUS  = 0;

	localparam int BIT_REF_POWER  = 7;
	localparam int BIT_REF_PIN    = 6;
	localparam int BIT_REF_RANGE  = 5;
	localparam int BIT_REF_SOURCE = 4;
	localparam int LEVEL_LSB      = 0;
	localparam int LEVEL_W        = 4;

	// analog control bundle for one comparator
	typedef struct packed {
		logic on;
		logic plus_select;
		logic minus_select;
		logic invert;
		logic pad_drive;
	} cmp_cfg_t;

	// analog control bundle for the reference ladder
	typedef struct packed {
		logic               power_on;
		logic               pin_drive;
		logic               range_select;
		logic               source_select;
		logic [LEVEL_W-1:0] level_select;
	} ref_cfg_t;

endpackage : cmp_vref_pkg

// >>> core/cmp_vref_ctrl.sv
// register bank steering two analog comparators and their voltage reference
// assumes raw comparator outputs arrive asynchronously from the analog macro
`timescale 1ns/100ps
`default_nettype none
module cmp_vref_ctrl
	import cmp_vref_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        idle_mode_i,
	input  wire logic [1:0]  cmp_raw_i,
	output cmp_cfg_t         cmp1_cfg_o,
	output cmp_cfg_t         cmp2_cfg_o,
	output ref_cfg_t         ref_cfg_o,
	output logic      [1:0]  cmp_pad_o,
	output logic             irq_o
);

	logic [15:0] cmp_ctrl_q, cmp_ctrl_d;
	logic [15:0] ref_ctrl_q, ref_ctrl_d;
	logic [1:0]  mask_q, mask_d;
	logic [1:0]  evt_q, evt_d;
	logic [1:0]  sync1_q, sync2_q, res_q, res_d;
	logic        res_valid_q, res_valid_d;
	logic [15:0] rdata_d;
	logic [1:0]  pad_d;
	logic        irq_d;
	cmp_cfg_t    cfg1_d, cfg2_d;
	ref_cfg_t    rcfg_d;
	logic [1:0]  on_v, inv_v, pad_v;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction : hit

	assign on_v  = {cmp_ctrl_q[BIT_CMP2_ON], cmp_ctrl_q[BIT_CMP1_ON]};
	assign inv_v = {cmp_ctrl_q[BIT_CMP2_INV], cmp_ctrl_q[BIT_CMP1_INV]};
	assign pad_v = {cmp_ctrl_q[BIT_CMP2_PAD], cmp_ctrl_q[BIT_CMP1_PAD]};

	// raw outputs come from the analog side, so two stages before any use
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
		end else begin
			sync1_q <= cmp_raw_i;
			sync2_q <= sync1_q;
		end
	end

	always_comb begin
		res_d       = 2'h0;
		evt_d       = evt_q;
		res_valid_d = 1'b0;
		for (int i = 0; i < 2; i++) begin
			// a disabled comparator reads low and cannot flag a change
			res_d[i] = on_v[i] & (sync2_q[i] ^ inv_v[i]);
		end
		res_valid_d = |on_v;
		// write-one clears, but a coincident change wins
		if (wr_i && hit(addr_i, ADDR_IRQ_STATUS)) begin
			evt_d = evt_d & ~wdata_i[1:0];
		end
		if (wr_i && hit(addr_i, ADDR_CMP_CTRL)) begin
			evt_d = evt_d & ~wdata_i[BIT_CMP2_EVT:BIT_CMP1_EVT];
		end
		for (int i = 0; i < 2; i++) begin
			if (on_v[i] && res_valid_q && (res_d[i] != res_q[i])) begin
				evt_d[i] = 1'b1;
			end
		end
	end

	always_comb begin
		cmp_ctrl_d = cmp_ctrl_q;
		ref_ctrl_d = ref_ctrl_q;
		mask_d     = mask_q;
		if (wr_i && hit(addr_i, ADDR_CMP_CTRL)) begin
			cmp_ctrl_d = wdata_i & CMP_CTRL_WMASK;
		end
		if (wr_i && hit(addr_i, ADDR_REF_CTRL)) begin
			ref_ctrl_d = wdata_i & REF_CTRL_WMASK;
		end
		if (wr_i && hit(addr_i, ADDR_IRQ_MASK)) begin
			mask_d = wdata_i[1:0];
		end
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (rd_i) begin
			unique case (addr_i)
				ADDR_CMP_CTRL: begin
					rdata_d = cmp_ctrl_q;
					rdata_d[BIT_CMP2_EVT:BIT_CMP1_EVT] = evt_q;
					rdata_d[BIT_CMP2_RES:BIT_CMP1_RES] = res_q;
				end
				ADDR_REF_CTRL:   rdata_d = ref_ctrl_q;
				ADDR_IRQ_STATUS: rdata_d = {14'h0000, evt_q};
				ADDR_IRQ_MASK:   rdata_d = {14'h0000, mask_q};
				default:         rdata_d = 16'h0000;
			endcase
		end
	end

	always_comb begin
		cfg1_d.on           = cmp_ctrl_q[BIT_CMP1_ON];
		cfg1_d.plus_select  = cmp_ctrl_q[BIT_CMP1_PLUS];
		cfg1_d.minus_select = cmp_ctrl_q[BIT_CMP1_MINUS];
		cfg1_d.invert       = cmp_ctrl_q[BIT_CMP1_INV];
		cfg1_d.pad_drive    = cmp_ctrl_q[BIT_CMP1_PAD];
		cfg2_d.on           = cmp_ctrl_q[BIT_CMP2_ON];
		cfg2_d.plus_select  = cmp_ctrl_q[BIT_CMP2_PLUS];
		cfg2_d.minus_select = cmp_ctrl_q[BIT_CMP2_MINUS];
		cfg2_d.invert       = cmp_ctrl_q[BIT_CMP2_INV];
		cfg2_d.pad_drive    = cmp_ctrl_q[BIT_CMP2_PAD];
		rcfg_d.power_on      = ref_ctrl_q[BIT_REF_POWER];
		rcfg_d.pin_drive     = ref_ctrl_q[BIT_REF_PIN];
		rcfg_d.range_select  = ref_ctrl_q[BIT_REF_RANGE];
		rcfg_d.source_select = ref_ctrl_q[BIT_REF_SOURCE];
		rcfg_d.level_select  = ref_ctrl_q[LEVEL_LSB +: LEVEL_W];
		// pad stays low unless driven; pin routing is software's job
		pad_d = res_q & pad_v;
		// in idle with stop set the comparators keep running and still drive their pads, but raise no interrupt
		irq_d = |(evt_q & mask_q) & ~(cmp_ctrl_q[BIT_IDLE_STOP] & idle_mode_i);
	end

	// control words and interrupt mask
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmp_ctrl_q <= CMP_CTRL_RESET;
			ref_ctrl_q <= REF_CTRL_RESET;
			mask_q     <= IRQ_RESET;
		end else begin
			cmp_ctrl_q <= cmp_ctrl_d;
			ref_ctrl_q <= ref_ctrl_d;
			mask_q     <= mask_d;
		end
	end

	// decisions and sticky change flags
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			evt_q       <= IRQ_RESET;
			res_q       <= 2'h0;
			res_valid_q <= 1'b0;
		end else begin
			evt_q       <= evt_d;
			res_q       <= res_d;
			res_valid_q <= res_valid_d;
		end
	end

	// read data stand only in the slot after the strobe, so a stale word is never seen
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// analog controls, pads and interrupt all leave from flops to keep the macro glitch free
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmp1_cfg_o <= '0;
			cmp2_cfg_o <= '0;
			ref_cfg_o  <= '0;
			cmp_pad_o  <= 2'h0;
			irq_o      <= 1'b0;
		end else begin
			cmp1_cfg_o <= cfg1_d;
			cmp2_cfg_o <= cfg2_d;
			ref_cfg_o  <= rcfg_d;
			cmp_pad_o  <= pad_d;
			irq_o      <= irq_d;
		end
	end

endmodule : cmp_vref_ctrl
`default_nettype wire

// >>> sim/cmp_vref_ctrl_asserts.sv
// port checker for the comparator and reference control block
// assumes one clock domain; bound onto the top module by name
`timescale 1ns/100ps
`default_nettype none
module cmp_vref_ctrl_asserts
	import cmp_vref_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        reset_n_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire cmp_cfg_t    cmp1_cfg_o,
	input wire cmp_cfg_t    cmp2_cfg_o,
	input wire ref_cfg_t    ref_cfg_o,
	input wire logic [1:0]  cmp_pad_o,
	input wire logic        idle_mode_i,
	input wire logic        irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	logic stop_q;
	// mirror of the idle stop bit, the one control bit that no port shows
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stop_q <= 1'b0;
		end else if (wr_i && addr_i == ADDR_CMP_CTRL) begin
			stop_q <= wdata_i[BIT_IDLE_STOP];
		end
	end
	sequence s_w0; wr_i && addr_i == ADDR_CMP_CTRL; endsequence
	sequence s_w1; wr_i && addr_i == ADDR_REF_CTRL; endsequence
	property p_c1; s_w0 |-> ##2 {cmp1_cfg_o.invert, cmp1_cfg_o.minus_select,
		cmp1_cfg_o.plus_select} == {$past(wdata_i[4], 2), $past(wdata_i[1:0], 2)}; endproperty
	a_c1: assert property (p_c1) else $error("cmp1 routing");
	property p_c2; s_w0 |-> ##2 {cmp2_cfg_o.invert, cmp2_cfg_o.minus_select,
		cmp2_cfg_o.plus_select} == {$past(wdata_i[5], 2), $past(wdata_i[3:2], 2)}; endproperty
	a_c2: assert property (p_c2) else $error("cmp2 routing");
	property p_on; s_w0 |-> ##2 {cmp2_cfg_o.on, cmp1_cfg_o.on} == $past(wdata_i[11:10], 2); endproperty
	a_on: assert property (p_on) else $error("enables");
	property p_lvl; s_w1 |-> ##2 ref_cfg_o.level_select == $past(wdata_i[3:0], 2); endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_ref; s_w1 |=> ##1 ref_cfg_o[7:4] == $past(wdata_i[7:4], 2); endproperty
	a_ref: assert property (p_ref) else $error("reference bits");
	property p_pad1; !cmp1_cfg_o.pad_drive && $past(!cmp1_cfg_o.pad_drive) |-> !cmp_pad_o[0]; endproperty
	a_pad1: assert property (p_pad1) else $error("pad1 driven");
	property p_pad2; !cmp2_cfg_o.pad_drive [*2] |-> !cmp_pad_o[1]; endproperty
	a_pad2: assert property (p_pad2) else $error("pad2 driven");
	property p_rdz; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside slot");
	property p_idle; stop_q && idle_mode_i |=> !irq_o; endproperty
	a_idle: assert property (p_idle) else $error("interrupt during idle stop");
	c_irq: cover property ($rose(irq_o));
	c_pad: cover property ($rose(cmp_pad_o[0]));
	c_ref: cover property (s_w1);
	c_on: cover property ($rose(cmp1_cfg_o.on));
endmodule : cmp_vref_ctrl_asserts
bind cmp_vref_ctrl cmp_vref_ctrl_asserts chk_u (
	.clock_i     (clock_i),
	.reset_n_i   (reset_n_i),
	.addr_i      (addr_i),
	.wdata_i     (wdata_i),
	.wr_i        (wr_i),
	.rd_i        (rd_i),
	.rdata_o     (rdata_o),
	.cmp1_cfg_o  (cmp1_cfg_o),
	.cmp2_cfg_o  (cmp2_cfg_o),
	.ref_cfg_o   (ref_cfg_o),
	.cmp_pad_o   (cmp_pad_o),
	.idle_mode_i (idle_mode_i),
	.irq_o       (irq_o)
);
`default_nettype wire

// >>> sim/analog_cmp_model.sv
// stand-in for the two analog comparators
// assumes the bench sets which plus inputs exceed their minus inputs
`timescale 1ns/100ps
`default_nettype none
module analog_cmp_model
	import cmp_vref_pkg::*;
(
	input wire logic [1:0] sense_i,
	input wire cmp_cfg_t   c1_i,
	input wire cmp_cfg_t   c2_i,
	output logic     [1:0] raw_o
);
	// a powered-down comparator gives no decision, so it rests low
	assign raw_o = sense_i & {c2_i.on, c1_i.on};
endmodule : analog_cmp_model
`default_nettype wire

// >>> sim/cmp_vref_ctrl_bench.sv
// self-checking bench for the comparator and reference control block
// assumes the analog stand-in model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module cmp_vref_ctrl_bench;
	logic clock_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, idle_mode_i = 0, rd_q = 0, irq_o;
	logic [3:0] addr_i = 0;
	logic [15:0] wdata_i = 0, d, rdata_o;
	logic [1:0] sense = 0, raw, cmp_pad_o;
	cmp_vref_pkg::cmp_cfg_t c1, c2;
	int num_errors = 0, checks = 0, seed = 32'he2ebc237;
	logic [15:0] expq[$];
	initial forever #4 clock_i = ~clock_i;
	cmp_vref_ctrl dut_u (.clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.idle_mode_i, .cmp_raw_i(raw), .cmp1_cfg_o(c1), .cmp2_cfg_o(c2), .ref_cfg_o(),
		.cmp_pad_o, .irq_o);
	analog_cmp_model cmp_u (.sense_i(sense), .c1_i(c1), .c2_i(c2), .raw_o(raw));
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// reads note their expectation; the monitor compares in the data slot
	task automatic bus(logic r, logic [3:0] a, logic [15:0] v);
		if (r) expq.push_back(v);
		wr_i <= !r;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clock_i);
		wr_i <= 0;
		rd_i <= 0;
		@(posedge clock_i);
	endtask : bus
	always @(posedge clock_i) rd_q <= rd_i;
	always @(negedge clock_i) if (rd_q) chk("read", expq.pop_front(), rdata_o);
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (5000) @(posedge clock_i);
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1;
		@(posedge clock_i);
		for (int a = 0; a < 5; a++) bus(1, 4'(a), 0);
		$display("reset test done");
		repeat (4) begin
			d = 16'($random(seed));
			bus(0, 1, d);
			bus(1, 1, d & 16'h00ff);
			d = d & 16'h833f;
			bus(0, 0, d);
			bus(1, 0, d);
		end
		$display("config test done");
		bus(0, 3, 16'h0003);
		// the pad output stands for a pin that software has already routed
		bus(0, 0, 16'h0d00);
		sense <= 2'b01;
		repeat (8) @(posedge clock_i);
		chk("irq", 1, 16'(irq_o));
		chk("pad", 1, 16'(cmp_pad_o));
		bus(1, 0, 16'h1d40);
		bus(0, 2, 16'h0001);
		// inverting cmp1 drops its result, a fresh event, while idle stop hides it
		bus(0, 0, 16'h8d10);
		idle_mode_i <= 1;
		repeat (8) @(posedge clock_i);
		chk("idle irq", 0, 16'(irq_o));
		bus(1, 2, 16'h0001);
		idle_mode_i <= 0;
		repeat (3) @(posedge clock_i);
		chk("irq", 1, 16'(irq_o));
		bus(1, 0, 16'h9d10);
		bus(0, 3, 16'h0000);
		repeat (2) @(posedge clock_i);
		chk("masked irq", 0, 16'(irq_o));
		// second comparator rises while the first stays inverted low
		sense <= 2'b11;
		repeat (6) @(posedge clock_i);
		bus(1, 2, 16'h0003);
		bus(1, 0, 16'hbd90);
		$display("event test done");
		complete_run();
	end
endmodule : cmp_vref_ctrl_bench
`default_nettype wire
